// [hw/key_matrix_scan_request.v]
// key matrix scanner: drives scan lines, senses returns, raises a read-ready flag,
// and answers key status reads on the serial link.
// assumes link pins (chip select, shift clock, data) and key returns are asynchronous.
// Function
// [R1] key_ready_out rises once two complete scan cycles pass after any key closes.
// [R2] key_ready_out falls once a scan finds every key open.
// [R3] the host should start a key read on the rising edge of key_ready_out.
// [R4] a read started on the falling edge may be unstable and should be repeated three times.
// [R5] a key read started while key_ready_out is low returns all keys open.
// [R6] the five active-low scan lines go low one at a time in ascending order.
// [R7] sense inputs idle high by pull-up and a closed key reads low on its input.
// [R8] holding reset low puts every register into its initial state.
// [R9] master timing comes from the clock on osc_in, osc_out being left open.
// [R10] the data pin drives only after a key or memory read command until chip select rises.
// [R11] on a key read a closed key is sent high and an open key low.
// [R12] the 25 key states of the latest complete scan cycle are held for reads.
// [R13] the scan runs continuously, wrapping from the fifth line back to the first.
`timescale 1ns/1ns
`include "key_scan_defs.vh"
module key_matrix_scan_request #(
   parameter LINES = `KS_LINES,
   parameter LINE_CLKS = `KS_LINE_CLKS,
   parameter READY_CYCLES = `KS_READY_CYCLES
) (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire osc_in,
   output wire osc_out,
   output wire [LINES-1:0] scan_drive_n,
   input wire [LINES-1:0] key_sense_n,
   input wire chip_sel_n,
   input wire shift_clock_in,
   input wire serial_data_in,
   output reg serial_data_out,
   output wire serial_data_oe,
   output reg key_ready_out
);
   localparam KEYS = LINES * LINES;
   localparam ST_CMD = 3'b001;
   localparam ST_SEND = 3'b010;
   localparam ST_DONE = 3'b100;

   // two-flop synchronisers; the first stage feeds only the second
   reg [LINES-1:0] sense_m_q;
   reg [LINES-1:0] sense_s_q;
   reg [3:0] pin_m_q;
   reg [3:0] pin_s_q;
   reg osc_prev_q;
   reg cp_prev_q;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         sense_m_q <= {LINES{1'b1}};
         sense_s_q <= {LINES{1'b1}};
         // idle levels: select high, shift clock high, data high, osc low; no false edge
         pin_m_q <= 4'hE;
         pin_s_q <= 4'hE;
         osc_prev_q <= 1'b0;
         cp_prev_q <= 1'b1;
      end else if (clk_en) begin
         sense_m_q <= key_sense_n;
         sense_s_q <= sense_m_q;
         pin_m_q <= {chip_sel_n, shift_clock_in, serial_data_in, osc_in};
         pin_s_q <= pin_m_q;
         osc_prev_q <= pin_s_q[0];
         cp_prev_q <= pin_s_q[2];
      end
   end
   wire cs_n = pin_s_q[3];
   wire cp_s = pin_s_q[2];
   wire din_s = pin_s_q[1];
   // master timing ticks on each rising osc_in edge
   wire osc_tick = pin_s_q[0] & ~osc_prev_q; // [R9]
   // external clock mode only: nothing to drive on the oscillator output
   assign osc_out = 1'b0; // [R9]
   wire cp_rise = cp_s & ~cp_prev_q;
   wire cp_fall = ~cp_s & cp_prev_q;

   // scan sequencer
   reg [7:0] tick_cnt_q;
   reg [2:0] line_q;
   reg [KEYS-1:0] work_q;
   reg any_closed_q;
   reg [1:0] held_cnt_q;
   wire line_end = osc_tick && (tick_cnt_q == LINE_CLKS - 1);
   wire cycle_end = line_end && (line_q == LINES - 1);
   genvar g;
   generate
      for (g = 0; g < LINES; g = g + 1) begin : g_drive
         assign scan_drive_n[g] = ~(line_q == g); // [R6]
      end
   endgenerate

   // key closure is a low on a sense input while its line is driven
   wire [LINES-1:0] closed_now = ~sense_s_q; // [R7]
   wire [KEYS-1:0] cycle_keys = work_q | ({{(KEYS-LINES){1'b0}}, closed_now} << (line_q * LINES));
   wire cycle_any = |cycle_keys;

   always @(posedge ref_clk) begin
      if (!rst_b) begin // [R8]
         tick_cnt_q <= 8'h00;
         line_q <= 3'h0;
         work_q <= {KEYS{1'b0}};
         any_closed_q <= 1'b0;
         held_cnt_q <= 2'h0;
         key_ready_out <= 1'b0;
      end else if (clk_en && osc_tick) begin
         tick_cnt_q <= line_end ? 8'h00 : tick_cnt_q + 8'h01;
         if (line_end) begin
            // sample at end of line so the return has settled through the synchroniser
            if (cycle_end) begin
               line_q <= 3'h0; // [R13]
               work_q <= {KEYS{1'b0}};
               any_closed_q <= cycle_any;
               if (!cycle_any) begin
                  held_cnt_q <= 2'h0;
                  key_ready_out <= 1'b0; // [R2]
               end else if (held_cnt_q == READY_CYCLES - 1) begin
                  key_ready_out <= 1'b1; // [R1]
               end else begin
                  held_cnt_q <= held_cnt_q + 2'h1;
               end
            end else begin
               line_q <= line_q + 3'h1; // [R6]
               work_q <= cycle_keys;
            end
         end
      end
   end

   // snapshot of the last full cycle
   wire snap_wr = clk_en && osc_tick && cycle_end;
   wire [KEYS-1:0] snap_data;
   reg snap_rd;
   key_snap_reg #(
      .WIDTH(KEYS)
   ) u_snap (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .wr_en(snap_wr), // [R12]
      .wr_data(cycle_keys),
      .rd_en(snap_rd),
      .rd_data(snap_data)
   );

   // serial read path: command in on rising shift clock, data out on falling
   reg [2:0] st_q;
   reg [7:0] cmd_q;
   reg [3:0] bit_cnt_q;
   reg [4:0] out_idx_q;
   reg key_mode_q;
   reg ready_at_cmd_q;
   wire [7:0] cmd_next = {cmd_q[6:0], din_s};
   // both read commands turn the data pin around
   function is_read_cmd;
      input [7:0] code;
      begin
         is_read_cmd = (code == `KS_CMD_KEY_READ) || (code == `KS_CMD_RAM_READ);
      end
   endfunction
   function is_key_cmd;
      input [7:0] code;
      begin
         is_key_cmd = (code == `KS_CMD_KEY_READ);
      end
   endfunction
   assign serial_data_oe = (st_q == ST_SEND) & ~cs_n; // [R10]
   always @* begin
      snap_rd = 1'b0;
      if (st_q == ST_CMD && cp_rise && bit_cnt_q == `KS_CMD_BITS - 1 && is_read_cmd(cmd_next)) begin
         snap_rd = 1'b1;
      end
   end
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         st_q <= ST_CMD;
         cmd_q <= 8'h00;
         bit_cnt_q <= 4'h0;
         out_idx_q <= 5'h00;
         key_mode_q <= 1'b0;
         ready_at_cmd_q <= 1'b0;
         serial_data_out <= 1'b0;
      end else if (clk_en) begin
         if (cs_n) begin
            // chip select high ends any read and returns the pin to input
            st_q <= ST_CMD; // [R10]
            bit_cnt_q <= 4'h0;
            out_idx_q <= 5'h00;
            serial_data_out <= 1'b0;
         end else begin
            case (st_q)
               ST_CMD: begin
                  if (cp_rise) begin
                     cmd_q <= cmd_next;
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                     if (bit_cnt_q == `KS_CMD_BITS - 1) begin
                        if (is_read_cmd(cmd_next)) begin
                           st_q <= ST_SEND; // [R10]
                           key_mode_q <= is_key_cmd(cmd_next);
                           ready_at_cmd_q <= key_ready_out;
                        end else begin
                           st_q <= ST_DONE;
                        end
                     end
                  end
               end
               ST_SEND: begin
                  if (cp_fall) begin
                     // ready low at command time reads as all keys open
                     serial_data_out <= key_mode_q & ready_at_cmd_q & snap_data[out_idx_q]; // [R5] [R11]
                     out_idx_q <= (out_idx_q == KEYS - 1) ? 5'h00 : out_idx_q + 5'h01;
                  end
               end
               ST_DONE: begin
                  st_q <= ST_DONE;
               end
               default: begin
                  st_q <= ST_CMD;
               end
            endcase
         end
      end
   end
endmodule

// [hw/key_scan_defs.vh]
// constants for the key matrix scanner with read-ready flag
// assumes the includer runs on ref_clk at 250 MHz
`ifndef KEY_SCAN_DEFS_VH
`define KEY_SCAN_DEFS_VH
`define KS_LINES 5
`define KS_KEYS 25
`define KS_READY_CYCLES 2
`define KS_LINE_CLKS 16
`define KS_CMD_BITS 8
`define KS_CMD_KEY_READ 8'h4A
`define KS_CMD_RAM_READ 8'h4B
`endif

// [hw/key_snap_reg.v]
// snapshot store for the key states of one complete scan cycle
// assumes writer and reader share ref_clk; read data come from a register
`timescale 1ns/1ns
module key_snap_reg #(
   parameter WIDTH = 25
) (
   input wire ref_clk,
   input wire rst_b,
   input wire clk_en,
   input wire wr_en,
   input wire [WIDTH-1:0] wr_data,
   input wire rd_en,
   output reg [WIDTH-1:0] rd_data
);
   reg [WIDTH-1:0] store_q;
   always @(posedge ref_clk) begin
      if (!rst_b) begin
         store_q <= {WIDTH{1'b0}};
         rd_data <= {WIDTH{1'b0}};
      end else if (clk_en) begin
         if (wr_en) begin
            store_q <= wr_data;
         end
         if (rd_en) begin
            rd_data <= wr_en ? wr_data : store_q;
         end
      end
   end
endmodule

// [sim/key_host.sv]
// host model on the serial link
// assumes xfer is called with chip select idle high
`timescale 1ns/1ns
module key_host (
   output logic chip_sel_n,
   output logic shift_clock_in,
   output wire serial_data_in,
   input wire serial_data_out,
   input wire serial_data_oe
);
   logic drv = 1;
   logic seen_oe;
   // device wins the pin while enabled; host toggles its bit so no stale level survives
   assign serial_data_in = serial_data_oe ? serial_data_out : drv;
   initial chip_sel_n = 1;
   initial shift_clock_in = 1;
   task automatic xfer(input logic [7:0] cmd, output logic [24:0] d);
      seen_oe = 0;
      chip_sel_n = 0;
      for (int i = 0; i < 33; i++) begin
         shift_clock_in = 0;
         drv = i < 8 ? cmd[7-i] : ~drv;
         #62;
         shift_clock_in = 1;
         if (i > 7) d[i-8] = serial_data_in;
         seen_oe |= serial_data_oe;
         #63;
      end
      chip_sel_n = 1;
      #250;
   endtask
endmodule

// [sim/key_matrix_scan_request_tb.sv]
// self-checking bench for the key matrix scanner
// assumes a switch matrix with a diode per key (no ghost keys) and the host model on the link
`timescale 1ns/1ns
`include "key_scan_defs.vh"
module key_matrix_scan_request_tb;
   logic ref_clk = 0;
   logic rst_b = 0;
   logic osc_in = 0;
   logic [24:0] keys = 0;
   logic [24:0] d;
   logic [4:0] scan_drive_n;
   logic [4:0] key_sense_n;
   wire chip_sel_n, shift_clock_in, serial_data_in, serial_data_out, serial_data_oe;
   wire key_ready_out;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int wraps;
   always #2 ref_clk = ~ref_clk;
   always #20 osc_in = ~osc_in;
   always @(negedge scan_drive_n[0]) wraps++;
   // a key pulls its return low only while its own line is driven
   always_comb
      for (int j = 0; j < 5; j++)
         key_sense_n[j] = ~|(~scan_drive_n &
            {keys[20+j], keys[15+j], keys[10+j], keys[5+j], keys[j]});
   key_matrix_scan_request #(.LINE_CLKS(2)) key_matrix_scan_request_inst (
      .ref_clk, .rst_b, .clk_en(1'b1), .osc_in, .osc_out(), .scan_drive_n, .key_sense_n,
      .chip_sel_n, .shift_clock_in, .serial_data_in, .serial_data_out, .serial_data_oe,
      .key_ready_out);
   key_host key_host_inst (.chip_sel_n, .shift_clock_in, .serial_data_in, .serial_data_out,
      .serial_data_oe);
   function automatic logic [24:0] exp_read(input logic [24:0] k, input logic rdy);
      return rdy ? k : 25'h0;
   endfunction
   task automatic cmp(input string what, input logic [24:0] exp, input logic [24:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic wait_rdy(input logic v);
      for (int n = 0; n < 3000 && key_ready_out !== v; n++)
         @(negedge ref_clk);
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         summarize;
      end
   end
   initial begin
      void'($urandom(32'h09544A04));
      repeat (16) @(negedge ref_clk);
      cmp("reset scan", 25'h1E, 25'(scan_drive_n));
      cmp("reset ready", 0, 25'(key_ready_out));
      rst_b = 1;
      for (int i = 0; i < 6; i++) begin
         keys = i == 0 ? 25'h1 : i == 1 ? 25'h1000000 : 25'($urandom % 32'h1FFFFFF + 1);
         wraps = 0;
         wait_rdy(1);
         cmp("ready cycles", 1, 25'(wraps inside {[2:3]}));
         key_host_inst.xfer(`KS_CMD_KEY_READ, d);
         cmp("key read", exp_read(keys, 1), d);
         cmp("read oe", 1, 25'(key_host_inst.seen_oe));
         keys = 0;
         wraps = 0;
         wait_rdy(0);
         cmp("release cycles", 1, 25'(wraps inside {[1:2]}));
         repeat (3) begin
            key_host_inst.xfer(`KS_CMD_KEY_READ, d);
            cmp("idle read", exp_read(keys, 0), d);
         end
         $display("test %0d done", i);
      end
      key_host_inst.xfer(8'h00, d);
      cmp("refused oe", 0, 25'(key_host_inst.seen_oe));
      key_host_inst.xfer(`KS_CMD_RAM_READ, d);
      cmp("ram oe", 1, 25'(key_host_inst.seen_oe));
      $display("command test done");
      summarize;
   end
endmodule

// [sim/key_scan_checker_assertions.sv]
// port checker for the key matrix scanner
// assumes osc_in runs far slower than ref_clk
`timescale 1ns/1ns
module key_scan_checker #(parameter LINES = 5, LINE_CLKS = 16, READY_CYCLES = 2) (
   input wire ref_clk,
   input wire rst_b,
   input wire osc_in,
   input wire osc_out,
   input wire [LINES-1:0] scan_drive_n,
   input wire chip_sel_n,
   input wire serial_data_oe,
   input wire key_ready_out
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_cs_up;
      $rose(chip_sel_n);
   endsequence
   chk_scan_one_low: assert property ($onehot(~scan_drive_n)) else $error("scan lines");
   chk_scan_rotate: assert property ($changed(scan_drive_n) |-> scan_drive_n ==
      {$past(scan_drive_n[LINES-2:0]), $past(scan_drive_n[LINES-1])}) else $error("scan order");
   chk_ready_at_wrap: assert property ($changed(key_ready_out) |-> !scan_drive_n[0])
      else $error("ready off wrap");
   chk_oe_release: assert property (s_cs_up |-> ##[1:5] !serial_data_oe)
      else $error("pin not released");
   chk_oe_cause: assert property ($rose(serial_data_oe) |-> !chip_sel_n)
      else $error("drive unselected");
   chk_oe_hold: assert property (serial_data_oe && !chip_sel_n |=> serial_data_oe)
      else $error("drive dropped");
   chk_osc_open: assert property (osc_out == 1'b0) else $error("osc out");
   // a line may only step shortly after osc_in went high
   chk_scan_on_tick: assert property ($changed(scan_drive_n) |->
      $past(osc_in, 2) || $past(osc_in, 3)) else $error("step without tick");
   chk_reset_state: assert property ($rose(rst_b) |-> scan_drive_n == 5'h1E &&
      !key_ready_out && !serial_data_oe) else $error("reset state");
endmodule
bind key_matrix_scan_request key_scan_checker #(.LINES(LINES), .LINE_CLKS(LINE_CLKS),
   .READY_CYCLES(READY_CYCLES)) key_scan_checker_inst (.ref_clk, .rst_b, .osc_in, .osc_out,
   .scan_drive_n, .chip_sel_n, .serial_data_oe, .key_ready_out);
